/* File: design/dtc_pin_edge.sv */
// falling-edge detector for the external count pins
`timescale 1ns/10ps
`default_nettype none
module dtc_pin_edge
	import dtc_pkg::*;
(
	// clock and reset
	input  wire logic core_clk,
	input  wire logic sys_rst,
	// pin and event
	input  wire logic pinLevel,
	output logic      pinFall
);
	logic pinLast_reg;

	// pins are already synchronous, so a single stage suffices
	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
			pinLast_reg <= 1'b0;
		else
			pinLast_reg <= pinLevel;
	end

	// an event is counted when the pin goes back low
	assign pinFall = pinLast_reg && !pinLevel;
endmodule // dtc_pin_edge
`default_nettype wire

/* File: design/dtc_tick_div.sv */
// machine-cycle enable divider for the timer block
`timescale 1ns/10ps
`default_nettype none
module dtc_tick_div
	import dtc_pkg::*;
#(
	parameter int DIVIDE = MACHINE_DIV_DEF
)(
	// clock and reset
	input  wire logic core_clk,
	input  wire logic sys_rst,
	// enable out
	output logic      machineTick
);
	localparam int CW = $clog2(DIVIDE);
	logic [CW-1:0] divCount_reg;

	// one-cycle pulse once every DIVIDE clocks
	always_ff @(posedge core_clk)
	begin
		if (sys_rst || divCount_reg == CW'(DIVIDE - 1))
			divCount_reg <= '0;
		else
			divCount_reg <= divCount_reg + CW'(1);
	end

	assign machineTick = (divCount_reg == CW'(DIVIDE - 1)) && !sys_rst;
endmodule // dtc_tick_div
`default_nettype wire

/* File: design/dtc_timer_pair.sv */
// two 8-bit-pair timer/counters with modes 0..3 and shared control register
//
// Overview of operation
// RQ1: mode 0 counts 13 bits: low five bits of low byte plus high byte.
// RQ2: mode 0 low field counts 0..31, then wraps and bumps the high byte.
// RQ3: mode 0 wrap from 1fff to zero sets that counter's overflow flag.
// RQ4: mode 1 joins both bytes into one 16-bit counter, low byte least significant.
// RQ5: mode 1 low byte past 255 clears and increments high byte same step.
// RQ6: mode 1 wrap from ffff to zero sets that counter's overflow flag.
// RQ7: mode 2 counts only low byte; high byte is an untouched reload value.
// RQ8: mode 2 low byte incremented at 255 loads the reload value.
// RQ9: mode 2 with reload fd from fe runs ff, fd, fe repeating.
// RQ10: counter 0 mode 3 runs its two bytes as separate 8-bit wrapping counters.
// RQ11: split low byte uses counter 0 bits; split high byte uses counter 1 bits.
// RQ12: during split, counter 1 counts every machine cycle regardless of run bit.
// RQ13: counter 1 in mode 3 stops and keeps its count.
// RQ14: bit 7 set on counter 1 overflow, bit 5 on counter 0 overflow.
// RQ15: bit 6 runs counter 1, bit 4 runs counter 0.
// RQ16: control bits 7..4 are bit-addressable at 8f..8c, single bit writes.
// RQ17: mode fields select 0..3; counter 1 bits 5-4, counter 0 bits 1-0.
// RQ18: with gate set the gate pin must also be high to count.
// RQ19: with select set the counter steps on count pin pulses.
// RQ20: overflow flags stay set until software writes them zero.
`timescale 1ns/10ps
`default_nettype none
module dtc_timer_pair
	import dtc_pkg::*;
#(
	parameter int MACHINE_DIV = MACHINE_DIV_DEF
)(
	// clock and reset
	input  wire logic       core_clk,
	input  wire logic       sys_rst,
	// byte register port
	input  wire logic [7:0] regAddr,
	input  wire logic       regWrite,
	input  wire logic       regRead,
	input  wire logic [7:0] regWdata,
	output logic      [7:0] regRdata,
	// bit register port
	input  wire logic [7:0] bitAddr,
	input  wire logic       bitWrite,
	input  wire logic       bitWdata,
	// external pins
	input  wire logic       gate_pin_counter0,
	input  wire logic       gate_pin_counter1,
	input  wire logic       count_pin_counter0,
	input  wire logic       count_pin_counter1
);
	// ****************************************************************
	// state
	// ****************************************************************
	logic [7:0] counter0_low_byte_reg;
	logic [7:0] counter0_high_byte_reg;
	logic [7:0] counter1_low_byte_reg;
	logic [7:0] counter1_high_byte_reg;
	logic [7:0] timer_mode_select_reg;
	logic [3:0] ctlLow_reg;
	logic       counter1_overflow_flag_reg;
	logic       counter1_run_bit_reg;
	logic       counter0_overflow_flag_reg;
	logic       counter0_run_bit_reg;
	logic [7:0] regRdata_reg;

	logic       machineTick;
	logic       pinFall0;
	logic       pinFall1;
	dtc_mode_t  mode0;
	dtc_mode_t  mode1;
	logic       splitOn;
	logic       step0;
	logic       step1;
	logic       stepSplitHigh;
	logic       ovf0;
	logic       ovf1;
	logic [7:0] c0Low_next;
	logic [7:0] c0High_next;
	logic [7:0] c1Low_next;
	logic [7:0] c1High_next;
	logic       wrByte;
	logic       wrBit;

	// ****************************************************************
	// enables and pin events
	// ****************************************************************
	dtc_tick_div #(
		.DIVIDE (MACHINE_DIV)
	) u_div (
		.core_clk    (core_clk),
		.sys_rst     (sys_rst),
		.machineTick (machineTick)
	);

	dtc_pin_edge u_edge0 (
		.core_clk (core_clk),
		.sys_rst  (sys_rst),
		.pinLevel (count_pin_counter0),
		.pinFall  (pinFall0)
	);

	dtc_pin_edge u_edge1 (
		.core_clk (core_clk),
		.sys_rst  (sys_rst),
		.pinLevel (count_pin_counter1),
		.pinFall  (pinFall1)
	);

	// decide whether one counter takes an increment this cycle
	function automatic logic count_step(
		input logic [3:0] ctlNibble,
		input logic       runBit,
		input logic       gatePin,
		input logic       tick,
		input logic       pinEvent
	);
		logic enabled;
		logic source;
		enabled = runBit && (!ctlNibble[MODE_GATE_OFS] || gatePin); // RQ18
		source  = ctlNibble[MODE_SEL_OFS] ? pinEvent : tick; // RQ19
		return enabled && source;
	endfunction

	// mode fields decode straight from their binary value
	assign mode1   = dtc_mode_t'(timer_mode_select_reg[MODE_C1_LSB +: 2]); // RQ17
	assign mode0   = dtc_mode_t'(timer_mode_select_reg[MODE_C0_LSB +: 2]); // RQ17
	assign splitOn = (mode0 == DTC_SPLIT);

	// counter 0 (or split low byte) gated by counter 0's own bits
	assign step0 = count_step(timer_mode_select_reg[3:0], counter0_run_bit_reg,
		gate_pin_counter0, machineTick, pinFall0); // RQ15
	// split high byte borrows counter 1's run bit; it always times internally
	assign stepSplitHigh = splitOn && counter1_run_bit_reg && machineTick; // RQ11
	// counter 1 free-runs while split, halts in its own mode 3
	assign step1 = (mode1 == DTC_SPLIT) ? 1'b0 : // RQ13
		(splitOn ? machineTick : // RQ12
		count_step(timer_mode_select_reg[7:4], counter1_run_bit_reg,
		gate_pin_counter1, machineTick, pinFall1)); // RQ15

	// ****************************************************************
	// next-count arithmetic
	// ****************************************************************
	// counter 0 path, covering all four modes
	always_comb
	begin
		c0Low_next  = counter0_low_byte_reg;
		c0High_next = counter0_high_byte_reg;
		ovf0        = 1'b0;
		ovf1        = 1'b0;
		if (step0)
		begin
			case (mode0)
				DTC_MODE13:
				begin
					// upper three low-byte bits are outside the count
					if (counter0_low_byte_reg[4:0] == LOW5_MAX[4:0]) // RQ2
					begin
						c0Low_next  = {counter0_low_byte_reg[7:5], 5'h00}; // RQ1
						c0High_next = counter0_high_byte_reg + 8'h01; // RQ2
						ovf0        = (counter0_high_byte_reg == BYTE_MAX); // RQ3
					end
					else
						c0Low_next = counter0_low_byte_reg + 8'h01; // RQ1
				end
				DTC_MODE16:
				begin
					c0Low_next = counter0_low_byte_reg + 8'h01; // RQ4
					if (counter0_low_byte_reg == BYTE_MAX) // RQ5
					begin
						c0High_next = counter0_high_byte_reg + 8'h01; // RQ5
						ovf0        = (counter0_high_byte_reg == BYTE_MAX); // RQ6
					end
				end
				DTC_RELOAD8:
				begin
					// high byte is never written by counting
					if (counter0_low_byte_reg == BYTE_MAX) // RQ8
					begin
						c0Low_next = counter0_high_byte_reg; // RQ9
						ovf0       = 1'b1; // RQ20
					end
					else
						c0Low_next = counter0_low_byte_reg + 8'h01; // RQ7
				end
				DTC_SPLIT:
				begin
					c0Low_next = counter0_low_byte_reg + 8'h01; // RQ10
					ovf0       = (counter0_low_byte_reg == BYTE_MAX); // RQ11
				end
				default:
					c0Low_next = counter0_low_byte_reg;
			endcase
		end
		// split high byte runs on its own and flags counter 1
		if (stepSplitHigh)
		begin
			c0High_next = counter0_high_byte_reg + 8'h01; // RQ10
			ovf1        = (counter0_high_byte_reg == BYTE_MAX); // RQ11
		end
	end

	// counter 1 path; its overflow is lost to the flag during split
	always_comb
	begin
		c1Low_next  = counter1_low_byte_reg;
		c1High_next = counter1_high_byte_reg;
		if (step1)
		begin
			case (mode1)
				DTC_MODE13:
				begin
					if (counter1_low_byte_reg[4:0] == LOW5_MAX[4:0]) // RQ2
					begin
						c1Low_next  = {counter1_low_byte_reg[7:5], 5'h00}; // RQ1
						c1High_next = counter1_high_byte_reg + 8'h01; // RQ2
					end
					else
						c1Low_next = counter1_low_byte_reg + 8'h01; // RQ1
				end
				DTC_MODE16:
				begin
					c1Low_next = counter1_low_byte_reg + 8'h01; // RQ4
					if (counter1_low_byte_reg == BYTE_MAX)
						c1High_next = counter1_high_byte_reg + 8'h01; // RQ5
				end
				DTC_RELOAD8:
				begin
					if (counter1_low_byte_reg == BYTE_MAX)
						c1Low_next = counter1_high_byte_reg; // RQ8
					else
						c1Low_next = counter1_low_byte_reg + 8'h01; // RQ7
				end
				default:
					c1Low_next = counter1_low_byte_reg; // RQ13
			endcase
		end
	end

	// counter 1's own wrap flags only when split does not own the flag
	logic c1Wrap;
	always_comb
	begin
		c1Wrap = 1'b0;
		if (step1 && !splitOn)
		begin
			case (mode1)
				DTC_MODE13:
					c1Wrap = (counter1_low_byte_reg[4:0] == LOW5_MAX[4:0])
						&& (counter1_high_byte_reg == BYTE_MAX); // RQ3
				DTC_MODE16:
					c1Wrap = (counter1_low_byte_reg == BYTE_MAX)
						&& (counter1_high_byte_reg == BYTE_MAX); // RQ6
				DTC_RELOAD8:
					c1Wrap = (counter1_low_byte_reg == BYTE_MAX); // RQ20
				default:
					c1Wrap = 1'b0;
			endcase
		end
	end

	// ****************************************************************
	// register writes and counting
	// ****************************************************************
	assign wrByte = regWrite;
	assign wrBit  = bitWrite;

	// count bytes: a software write to the same byte wins over counting
	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			counter0_low_byte_reg  <= RESET_BYTE;
			counter0_high_byte_reg <= RESET_BYTE;
			counter1_low_byte_reg  <= RESET_BYTE;
			counter1_high_byte_reg <= RESET_BYTE;
		end
		else
		begin
			counter0_low_byte_reg  <= (wrByte && regAddr == ADDR_C0_LOW) ? regWdata : c0Low_next;
			counter0_high_byte_reg <= (wrByte && regAddr == ADDR_C0_HIGH) ? regWdata : c0High_next;
			counter1_low_byte_reg  <= (wrByte && regAddr == ADDR_C1_LOW) ? regWdata : c1Low_next;
			counter1_high_byte_reg <= (wrByte && regAddr == ADDR_C1_HIGH) ? regWdata : c1High_next;
		end
	end

	// mode register
	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
			timer_mode_select_reg <= RESET_BYTE;
		else if (wrByte && regAddr == ADDR_MODE_SELECT)
			timer_mode_select_reg <= regWdata; // RQ17
	end

	// run bits: byte write or single-bit write of the addressed bit only
	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			counter1_run_bit_reg <= 1'b0;
			counter0_run_bit_reg <= 1'b0;
			ctlLow_reg           <= RESET_CTL_LOW;
		end
		else if (wrByte && regAddr == ADDR_CONTROL_FLAGS)
		begin
			counter1_run_bit_reg <= regWdata[CTL_C1_RUN_BIT]; // RQ15
			counter0_run_bit_reg <= regWdata[CTL_C0_RUN_BIT]; // RQ15
			ctlLow_reg           <= regWdata[3:0];
		end
		else if (wrBit)
		begin
			if (bitAddr == BITADDR_C1_RUN)
				counter1_run_bit_reg <= bitWdata; // RQ16
			if (bitAddr == BITADDR_C0_RUN)
				counter0_run_bit_reg <= bitWdata; // RQ16
		end
	end

	// overflow flags: hardware set wins over a software clear in the same cycle
	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			counter1_overflow_flag_reg <= 1'b0;
			counter0_overflow_flag_reg <= 1'b0;
		end
		else
		begin
			if (ovf1 || c1Wrap)
				counter1_overflow_flag_reg <= 1'b1; // RQ14
			else if (wrByte && regAddr == ADDR_CONTROL_FLAGS)
				counter1_overflow_flag_reg <= regWdata[CTL_C1_OVF_BIT]; // RQ20
			else if (wrBit && bitAddr == BITADDR_C1_OVF)
				counter1_overflow_flag_reg <= bitWdata; // RQ16
			if (ovf0)
				counter0_overflow_flag_reg <= 1'b1; // RQ14
			else if (wrByte && regAddr == ADDR_CONTROL_FLAGS)
				counter0_overflow_flag_reg <= regWdata[CTL_C0_OVF_BIT]; // RQ20
			else if (wrBit && bitAddr == BITADDR_C0_OVF)
				counter0_overflow_flag_reg <= bitWdata; // RQ16
		end
	end

	// ****************************************************************
	// read port
	// ****************************************************************
	// registered read data, answered one cycle after the strobe
	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
			regRdata_reg <= RESET_BYTE;
		else if (regRead)
		begin
			case (regAddr)
				ADDR_CONTROL_FLAGS: regRdata_reg <= {counter1_overflow_flag_reg,
					counter1_run_bit_reg, counter0_overflow_flag_reg,
					counter0_run_bit_reg, ctlLow_reg};
				ADDR_MODE_SELECT:   regRdata_reg <= timer_mode_select_reg;
				ADDR_C0_LOW:        regRdata_reg <= counter0_low_byte_reg;
				ADDR_C1_LOW:        regRdata_reg <= counter1_low_byte_reg;
				ADDR_C0_HIGH:       regRdata_reg <= counter0_high_byte_reg;
				ADDR_C1_HIGH:       regRdata_reg <= counter1_high_byte_reg;
				default:            regRdata_reg <= RESET_BYTE;
			endcase
		end
	end

	assign regRdata = regRdata_reg;
endmodule // dtc_timer_pair
`default_nettype wire

/* File: shared/dtc_pkg.sv */
// package of constants for the dual timer/counter block
package dtc_pkg;
	// ****************************************************************
	// special-function register addresses
	// ****************************************************************
	localparam logic [7:0] ADDR_CONTROL_FLAGS = 8'h88;
	localparam logic [7:0] ADDR_MODE_SELECT   = 8'h89;
	localparam logic [7:0] ADDR_C0_LOW        = 8'h8a;
	localparam logic [7:0] ADDR_C1_LOW        = 8'h8b;
	localparam logic [7:0] ADDR_C0_HIGH       = 8'h8c;
	localparam logic [7:0] ADDR_C1_HIGH       = 8'h8d;

	// ****************************************************************
	// bit addresses of the control register upper nibble
	// ****************************************************************
	localparam logic [7:0] BITADDR_C1_OVF = 8'h8f;
	localparam logic [7:0] BITADDR_C1_RUN = 8'h8e;
	localparam logic [7:0] BITADDR_C0_OVF = 8'h8d;
	localparam logic [7:0] BITADDR_C0_RUN = 8'h8c;

	// ****************************************************************
	// field positions
	// ****************************************************************
	localparam int CTL_C1_OVF_BIT = 7;
	localparam int CTL_C1_RUN_BIT = 6;
	localparam int CTL_C0_OVF_BIT = 5;
	localparam int CTL_C0_RUN_BIT = 4;
	localparam int MODE_C1_LSB    = 4;
	localparam int MODE_C0_LSB    = 0;
	localparam int MODE_GATE_OFS  = 3;
	localparam int MODE_SEL_OFS   = 2;

	// ****************************************************************
	// reset values and widths
	// ****************************************************************
	localparam logic [7:0] RESET_BYTE      = 8'h00;
	localparam logic [3:0] RESET_CTL_LOW   = 4'h0;
	localparam logic [7:0] LOW5_MAX        = 8'h1f;
	localparam logic [7:0] BYTE_MAX        = 8'hff;
	localparam int         MACHINE_DIV_DEF = 12;

	// ****************************************************************
	// operating modes
	// ****************************************************************
	typedef enum logic [1:0] {
		DTC_MODE13  = 2'b00,
		DTC_MODE16  = 2'b01,
		DTC_RELOAD8 = 2'b10,
		DTC_SPLIT   = 2'b11
	} dtc_mode_t;
endpackage

/* File: test/dtc_timer_pair_checker.sv */
// register-port assertions for the dual timer/counter
`timescale 1ns/10ps
`default_nettype none
module dtc_timer_pair_checker
	import dtc_pkg::*;
#(
	parameter int MACHINE_DIV = MACHINE_DIV_DEF
)(
	// clock and reset
	input wire logic       core_clk,
	input wire logic       sys_rst,
	// register ports
	input wire logic [7:0] regAddr,
	input wire logic       regWrite,
	input wire logic       regRead,
	input wire logic [7:0] regWdata,
	input wire logic [7:0] regRdata,
	input wire logic [7:0] bitAddr,
	input wire logic       bitWrite,
	input wire logic       bitWdata
);
	// ********************************************
	// software-visible control and mode bits
	// ********************************************
	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);

	// control read, and a cycle with no software write that could mask hardware
	logic ctlRd;
	logic quiet;
	assign ctlRd = regRead && regAddr == ADDR_CONTROL_FLAGS;
	assign quiet = !regWrite && !bitWrite;

	sequence s_bit(logic [7:0] a);
		bitWrite && !regWrite && bitAddr == a;
	endsequence

	// hardware never alters the mode byte, so it reads back exactly as written
	property p_mode_rb;
		(regWrite && regAddr == ADDR_MODE_SELECT) ##1 (regRead && regAddr == ADDR_MODE_SELECT)
			|=> regRdata == $past(regWdata, 2);
	endproperty
	property p_low_rb;
		(regWrite && regAddr == ADDR_CONTROL_FLAGS) ##1 ctlRd
			|=> regRdata[3:0] == $past(regWdata[3:0], 2);
	endproperty
	property p_run0;
		s_bit(BITADDR_C0_RUN) ##1 ctlRd |=> regRdata[CTL_C0_RUN_BIT] == $past(bitWdata, 2);
	endproperty
	property p_run1;
		s_bit(BITADDR_C1_RUN) ##1 ctlRd |=> regRdata[CTL_C1_RUN_BIT] == $past(bitWdata, 2);
	endproperty
	// a set flag can only be cleared by software, so it must read back set
	property p_set0;
		(s_bit(BITADDR_C0_OVF) and bitWdata) ##1 ctlRd |=> regRdata[CTL_C0_OVF_BIT];
	endproperty
	property p_set1;
		(s_bit(BITADDR_C1_OVF) and bitWdata) ##1 ctlRd |=> regRdata[CTL_C1_OVF_BIT];
	endproperty
	property p_hold0;
		(ctlRd && quiet) ##1 (ctlRd && regRdata[CTL_C0_OVF_BIT]) |=> regRdata[CTL_C0_OVF_BIT];
	endproperty
	property p_hold1;
		(ctlRd && quiet) ##1 (ctlRd && regRdata[CTL_C1_OVF_BIT]) |=> $stable(regRdata[7]);
	endproperty

	a_mode_rb: assert property (p_mode_rb) else $error("mode byte readback");
	a_low_rb: assert property (p_low_rb) else $error("control low bits readback");
	a_run0: assert property (p_run0) else $error("run bit 0 readback");
	a_run1: assert property (p_run1) else $error("run bit 1 readback");
	a_set0: assert property (p_set0) else $error("flag 0 bit write");
	a_set1: assert property (p_set1) else $error("flag 1 bit write");
	a_hold0: assert property (p_hold0) else $error("flag 0 dropped");
	a_hold1: assert property (p_hold1) else $error("flag 1 dropped");

	// main scenarios reached
	c_ovf0: cover property (ctlRd ##1 regRdata[CTL_C0_OVF_BIT]);
	c_ovf1: cover property (ctlRd ##1 regRdata[CTL_C1_OVF_BIT]);
	c_mode: cover property ((regWrite && regAddr == ADDR_MODE_SELECT) ##1 regRead);
endmodule // dtc_timer_pair_checker

bind dtc_timer_pair dtc_timer_pair_checker #(.MACHINE_DIV(MACHINE_DIV)) u_dtc_timer_pair_checker (
	.core_clk(core_clk), .sys_rst(sys_rst), .regAddr(regAddr), .regWrite(regWrite),
	.regRead(regRead), .regWdata(regWdata), .regRdata(regRdata), .bitAddr(bitAddr),
	.bitWrite(bitWrite), .bitWdata(bitWdata));
`default_nettype wire

/* File: test/test_dtc_timer_pair.sv */
// self-checking bench for the dual timer/counter
`timescale 1ns/10ps
`default_nettype none
module test_dtc_timer_pair
	import dtc_pkg::*;
;
	logic        core_clk = 1'b0;
	logic        sys_rst  = 1'b1;
	logic [7:0]  regAddr  = 8'h00;
	logic [7:0]  regWdata = 8'h00;
	logic [7:0]  bitAddr  = 8'h00;
	logic [7:0]  regRdata;
	logic        regWrite = 1'b0;
	logic        regRead  = 1'b0;
	logic        bitWrite = 1'b0;
	logic        bitWdata = 1'b0;
	logic [1:0]  gatePins  = 2'b11;
	logic [1:0]  countPins = 2'b11;
	int          errors = 0;
	int          samples_checked = 0;
	int          cycles = 0;
	logic [31:0] rnd = 32'h92b48d75;
	logic [7:0]  v;

	// short divider keeps internal-tick scenarios brief
	dtc_timer_pair #(.MACHINE_DIV(2)) u_dtc_timer_pair (
		.core_clk(core_clk), .sys_rst(sys_rst), .regAddr(regAddr), .regWrite(regWrite),
		.regRead(regRead), .regWdata(regWdata), .regRdata(regRdata), .bitAddr(bitAddr),
		.bitWrite(bitWrite), .bitWdata(bitWdata), .gate_pin_counter0(gatePins[0]),
		.gate_pin_counter1(gatePins[1]), .count_pin_counter0(countPins[0]),
		.count_pin_counter1(countPins[1]));

	always #2 core_clk = ~core_clk;

	// ********************************************
	// bus tasks and reference model
	// ********************************************
	// every task sets all strobes, so none is assigned twice in one step
	task automatic put(input logic w, input logic r, input logic b);
		regWrite <= w;
		regRead  <= r;
		bitWrite <= b;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		put(1'b1, 1'b0, 1'b0);
		regAddr  <= a;
		regWdata <= d;
		@(posedge core_clk);
	endtask
	task automatic bw(input logic [7:0] a, input logic d);
		put(1'b0, 1'b0, 1'b1);
		bitAddr  <= a;
		bitWdata <= d;
		@(posedge core_clk);
	endtask
	// read strobe stays up two edges; the second read is harmless
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		put(1'b0, 1'b1, 1'b0);
		regAddr <= a;
		repeat (2) @(posedge core_clk);
		d = regRdata;
	endtask
	task automatic wt(input int n);
		put(1'b0, 1'b0, 1'b0);
		repeat (n) @(posedge core_clk);
	endtask
	task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
		samples_checked++;
		if (g !== e)
		begin
			errors++;
			$display("BAD %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic rdc(input logic [7:0] a, input string s, input logic [7:0] e);
		rd(a, v);
		chk(s, e, v);
	endtask
	// one falling edge on a count pin
	task automatic pulse(input int c);
		put(1'b0, 1'b0, 1'b0);
		countPins[c] <= 1'b0;
		repeat (2) @(posedge core_clk);
		countPins[c] <= 1'b1;
		repeat (2) @(posedge core_clk);
	endtask
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// reference counter: one count event in modes 0..2
	function automatic void step(input int m, inout int lo, inout int hi, inout int f);
		int wrap;
		if (m == 2)
		begin
			wrap = (lo == 255);
			lo = wrap ? hi : lo + 1;
		end
		else
		begin
			wrap = (m == 0) ? ((lo & 31) == 31) : (lo == 255);
			lo = (m == 0) ? ((lo & 224) | ((lo + 1) & 31)) : ((lo + 1) & 255);
			f = f | (wrap && hi == 255);
			hi = wrap ? ((hi + 1) & 255) : hi;
			wrap = 0;
		end
		f = f | wrap;
	endfunction

	// one counter on its count pin, gated, from a start near the wrap
	task automatic run_mode(input int c, input int m, input logic [7:0] l0, input logic [7:0] h0);
		int lo;
		int hi;
		int f;
		logic [7:0] aLo;
		logic [7:0] aHi;
		logic [7:0] aRun;
		lo = l0;
		hi = h0;
		f = 0;
		aLo = c ? ADDR_C1_LOW : ADDR_C0_LOW;
		aHi = c ? ADDR_C1_HIGH : ADDR_C0_HIGH;
		aRun = c ? BITADDR_C1_RUN : BITADDR_C0_RUN;
		wr(ADDR_CONTROL_FLAGS, 8'h00);
		wr(ADDR_MODE_SELECT, 8'(12 + m) << (4 * c));
		wr(aLo, l0);
		wr(aHi, h0);
		bw(aRun, 1'b1);
		gatePins[c] <= 1'b0;
		pulse(c);
		rdc(aLo, "gated", l0);
		gatePins[c] <= 1'b1;
		repeat (6)
		begin
			pulse(c);
			step(m, lo, hi, f);
			rdc(aLo, "low", 8'(lo));
		end
		rdc(aHi, "high", 8'(hi));
		bw(aRun, 1'b0);
		pulse(c);
		rdc(aLo, "stopped", 8'(lo));
		rd(ADDR_CONTROL_FLAGS, v);
		chk("ovf", 8'(f), {7'h0, v[c ? 7 : 5]});
	endtask

	task automatic summarize();
		$display("checked %0d mismatches %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// ********************************************
	// main sequence and hang guard
	// ********************************************
	initial
	begin
		repeat (8) @(posedge core_clk);
		sys_rst <= 1'b0;
		// all registers clear, address 8e is unmapped as a byte
		for (int a = 8'h88; a <= 8'h8e; a++)
			rdc(8'(a), "reset", 8'h00);
		wr(ADDR_CONTROL_FLAGS, 8'h0a);
		rdc(ADDR_CONTROL_FLAGS, "ctllow", 8'h0a);
		for (int i = 3; i >= 0; i--)
		begin
			bw(BITADDR_C0_RUN + 8'(i), 1'b1);
			rdc(ADDR_CONTROL_FLAGS, "bitset", 8'h0a | (8'hf0 << i));
		end
		for (int i = 3; i >= 0; i--)
		begin
			bw(BITADDR_C0_RUN + 8'(i), 1'b0);
			// only the upper nibble tracks the cleared bits; the low nibble stays 0a
			rdc(ADDR_CONTROL_FLAGS, "bitclr", 8'h0a | ((8'hf0 >> (4 - i)) & 8'hf0));
		end
		rnd = lfsr(rnd);
		wr(ADDR_MODE_SELECT, rnd[7:0]);
		rdc(ADDR_MODE_SELECT, "mode", rnd[7:0]);
		for (int c = 0; c < 2; c++)
		begin
			rnd = lfsr(rnd);
			run_mode(c, 0, {rnd[7:5], 5'h1e}, 8'hff);
			run_mode(c, 1, 8'hfe, 8'hff);
			run_mode(c, 2, 8'hfe, 8'hfd);
		end
		// split: low byte on pin 0, high byte under counter 1 run bit
		wr(ADDR_CONTROL_FLAGS, 8'h00);
		wr(ADDR_MODE_SELECT, 8'h17);
		wr(ADDR_C0_LOW, 8'hfe);
		wr(ADDR_C0_HIGH, 8'hfe);
		wr(ADDR_C1_LOW, 8'h00);
		bw(BITADDR_C0_RUN, 1'b1);
		repeat (3) pulse(0);
		rdc(ADDR_C0_LOW, "splitlow", 8'h01);
		rdc(ADDR_C0_HIGH, "splithigh", 8'hfe);
		rdc(ADDR_CONTROL_FLAGS, "splitflags", 8'h30);
		rd(ADDR_C1_LOW, v);
		chk("c1free", 8'h01, {7'h0, v != 8'h00});
		bw(BITADDR_C1_RUN, 1'b1);
		wt(8);
		rd(ADDR_CONTROL_FLAGS, v);
		chk("splitovf", 8'h01, {7'h0, v[7]});
		// counter 1 in mode 3 holds although its run bit is set
		wr(ADDR_MODE_SELECT, 8'h30);
		rd(ADDR_C1_LOW, v);
		wt(8);
		rdc(ADDR_C1_LOW, "c1halt", v);
		summarize();
	end

	// the sequence needs a few hundred cycles at most
	always @(posedge core_clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			errors++;
			summarize();
		end
	end
endmodule // test_dtc_timer_pair
`default_nettype wire
